// ### rtl/mfpd_regs.vh
// Behaviour
// - With the direction bit clear, the pin is an input; low code bits select its function.
// - Code 0x01: pin assertion acts as the I/O update bit, 0x0005 bit 0.
// - Code 0x02: pin acts as full power-down, 0x0A00 bit 0.
// - Code 0x03: pin clears the watchdog, 0x0A03 bit 0.
// - Code 0x04: pin clears all pending interrupts, 0x0A03 bit 1.
// - Code 0x05: pin resets tuning word history, 0x0A03 bit 2.
// - Code 0x10: pin forces user holdover, 0x0A01 bit 6.
// - Code 0x11: pin forces user free run, 0x0A01 bit 5.
// - Code 0x12: pin resets incremental phase offset, 0x0A0A bit 2.
// - Code 0x13: pin steps phase offset up, 0x0A0A bit 0.
// - Code 0x14: pin steps phase offset down, 0x0A0A bit 1.
// - Codes 0x20 to 0x23 override reference monitors A to D, 0x0A0C bits 0-3.
// - Codes 0x30 to 0x33 force validation timeout A to D, 0x0A0B bits 0-3.
// - Codes 0x40 to 0x45 enable clock outputs 0 to 5 individually.
// - Code 0x46 enables all six clock outputs together.
// - Code 0x47 issues a soft sync of distribution outputs, 0x0A02 bit 1.
`ifndef MFPD_REGS_VH
`define MFPD_REGS_VH

// ----------------------------------------
// Register addresses.
// ----------------------------------------
`define MFPD_ADDR_CFG 16'h0000
`define MFPD_ADDR_IO_UPDATE 16'h0005
`define MFPD_ADDR_OUT_EN0 16'h0501
`define MFPD_ADDR_OUT_EN1 16'h0505
`define MFPD_ADDR_OUT_EN2 16'h0506
`define MFPD_ADDR_OUT_EN3 16'h050a
`define MFPD_ADDR_OUT_EN4 16'h050b
`define MFPD_ADDR_OUT_EN5 16'h050f
`define MFPD_ADDR_POWER 16'h0a00
`define MFPD_ADDR_LOOP_MODE 16'h0a01
`define MFPD_ADDR_SYNC 16'h0a02
`define MFPD_ADDR_CLEAR 16'h0a03
`define MFPD_ADDR_PHASE 16'h0a0a
`define MFPD_ADDR_VAL_TIMEOUT 16'h0a0b
`define MFPD_ADDR_MON_OVERRIDE 16'h0a0c
`define MFPD_ADDR_STATUS 16'h0a10

// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define MFPD_DIR_BIT 7
`define MFPD_BIT_HOLDOVER 6
`define MFPD_BIT_FREERUN 5
`define MFPD_BIT_SOFT_SYNC 1
`define MFPD_CFG_RESET 8'h00

// ----------------------------------------
// Input function codes.
// ----------------------------------------
`define MFPD_FN_IO_UPDATE 8'h01
`define MFPD_FN_POWER_DOWN 8'h02
`define MFPD_FN_CLR_WATCHDOG 8'h03
`define MFPD_FN_CLR_IRQ 8'h04
`define MFPD_FN_TW_RESET 8'h05
`define MFPD_FN_HOLDOVER 8'h10
`define MFPD_FN_FREERUN 8'h11
`define MFPD_FN_PH_RESET 8'h12
`define MFPD_FN_PH_INC 8'h13
`define MFPD_FN_PH_DEC 8'h14
`define MFPD_FN_MON_BASE 6'h08
`define MFPD_FN_VAL_BASE 6'h0c
`define MFPD_FN_OUT_BASE 5'h08
`define MFPD_FN_OUT_ALL 8'h46
`define MFPD_FN_SOFT_SYNC 8'h47

`endif

// ### rtl/mfpd_sync.v
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Two-stage synchroniser with rising-edge pulse.
// ----------------------------------------
module mfpd_sync (
	input wire clk_sys,
	input wire resetn,
	input wire din,
	output reg level,
	output reg rise
);
	reg meta;
	always @(posedge clk_sys) begin
		if (!resetn) begin
			meta <= 1'b0;
			level <= 1'b0;
			rise <= 1'b0;
		end else begin
			meta <= din;
			level <= meta;
			rise <= meta & ~level;
		end
	end
endmodule // mfpd_sync

`default_nettype wire

// ### rtl/mfpd_top.v
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "mfpd_regs.vh"

module mfpd_top (
	input wire clk_sys,
	input wire resetn,
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire pin_in,
	output reg io_update,
	output reg power_down,
	output reg clr_watchdog,
	output reg clr_irq,
	output reg tw_history_reset,
	output reg user_holdover,
	output reg user_freerun,
	output reg phase_reset,
	output reg phase_inc,
	output reg phase_dec,
	output reg [3:0] ref_mon_override,
	output reg [3:0] force_val_timeout,
	output reg [5:0] clock_output_en,
	output reg soft_sync
);

	// ----------------------------------------
	// Pin synchroniser.
	// ----------------------------------------
	wire pin_lvl;
	wire pin_rise;
	mfpd_sync u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.din(pin_in),
		.level(pin_lvl),
		.rise(pin_rise)
	);

	// ----------------------------------------
	// Software control registers.
	// ----------------------------------------
	reg [7:0] cfg;
	reg sw_power;
	reg sw_holdover;
	reg sw_freerun;
	reg [3:0] sw_mon;
	reg [3:0] sw_val;
	reg [5:0] sw_out;
	wire pin_dir_select_bit;
	wire is_input;
	assign pin_dir_select_bit = cfg[`MFPD_DIR_BIT];
	assign is_input = ~pin_dir_select_bit;

	// ----------------------------------------
	// Software write strobes.
	// ----------------------------------------
	wire w_io;
	wire w_clear;
	wire w_phase;
	wire w_sync;
	wire w_cfg;
	wire w_power;
	wire w_loop;
	wire w_mon;
	wire w_val;
	wire [5:0] w_out;

	assign w_io = wr && addr == `MFPD_ADDR_IO_UPDATE;
	assign w_clear = wr && addr == `MFPD_ADDR_CLEAR;
	assign w_phase = wr && addr == `MFPD_ADDR_PHASE;
	assign w_sync = wr && addr == `MFPD_ADDR_SYNC;
	assign w_cfg = wr && addr == `MFPD_ADDR_CFG;
	assign w_power = wr && addr == `MFPD_ADDR_POWER;
	assign w_loop = wr && addr == `MFPD_ADDR_LOOP_MODE;
	assign w_mon = wr && addr == `MFPD_ADDR_MON_OVERRIDE;
	assign w_val = wr && addr == `MFPD_ADDR_VAL_TIMEOUT;
	assign w_out[0] = wr && addr == `MFPD_ADDR_OUT_EN0;
	assign w_out[1] = wr && addr == `MFPD_ADDR_OUT_EN1;
	assign w_out[2] = wr && addr == `MFPD_ADDR_OUT_EN2;
	assign w_out[3] = wr && addr == `MFPD_ADDR_OUT_EN3;
	assign w_out[4] = wr && addr == `MFPD_ADDR_OUT_EN4;
	assign w_out[5] = wr && addr == `MFPD_ADDR_OUT_EN5;

	// ----------------------------------------
	// Stored control bits.
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (!resetn) begin
			cfg <= `MFPD_CFG_RESET;
		end else if (w_cfg) begin
			cfg <= wdata;
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			sw_power <= 1'b0;
		end else if (w_power) begin
			sw_power <= wdata[0];
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			sw_holdover <= 1'b0;
			sw_freerun <= 1'b0;
		end else if (w_loop) begin
			sw_holdover <= wdata[`MFPD_BIT_HOLDOVER];
			sw_freerun <= wdata[`MFPD_BIT_FREERUN];
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			sw_mon <= 4'h0;
		end else if (w_mon) begin
			sw_mon <= wdata[3:0];
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			sw_val <= 4'h0;
		end else if (w_val) begin
			sw_val <= wdata[3:0];
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			sw_out <= 6'h00;
		end else begin
			if (w_out[0]) sw_out[0] <= wdata[0];
			if (w_out[1]) sw_out[1] <= wdata[0];
			if (w_out[2]) sw_out[2] <= wdata[0];
			if (w_out[3]) sw_out[3] <= wdata[0];
			if (w_out[4]) sw_out[4] <= wdata[0];
			if (w_out[5]) sw_out[5] <= wdata[0];
		end
	end

	// ----------------------------------------
	// Pin function decode.
	// ----------------------------------------
	wire [7:0] fn = is_input ? cfg : 8'hff;
	wire lvl_on = pin_lvl;
	wire edge_on = pin_rise;
	reg [3:0] pin_mon;
	reg [3:0] pin_val;
	reg [5:0] pin_out;
	always @* begin
		pin_mon = 4'h0;
		pin_val = 4'h0;
		pin_out = 6'h00;
		if (fn[7:2] == `MFPD_FN_MON_BASE)
			pin_mon[fn[1:0]] = lvl_on;
		if (fn[7:2] == `MFPD_FN_VAL_BASE)
			pin_val[fn[1:0]] = lvl_on;
		if (fn[7:3] == `MFPD_FN_OUT_BASE && fn[2:0] < 3'h6)
			pin_out[fn[2:0]] = lvl_on;
		if (fn == `MFPD_FN_OUT_ALL)
			pin_out = {6{lvl_on}};
	end

	// ----------------------------------------
	// Pin level selects.
	// ----------------------------------------
	wire sel_power_down;
	wire sel_holdover;
	wire sel_freerun;

	assign sel_power_down = lvl_on & (fn == `MFPD_FN_POWER_DOWN);
	assign sel_holdover = lvl_on & (fn == `MFPD_FN_HOLDOVER);
	assign sel_freerun = lvl_on & (fn == `MFPD_FN_FREERUN);

	// ----------------------------------------
	// Pin edge selects.
	// ----------------------------------------
	wire sel_io_update;
	wire sel_clr_watchdog;
	wire sel_clr_irq;
	wire sel_tw_reset;
	wire sel_ph_reset;
	wire sel_ph_inc;
	wire sel_ph_dec;
	wire sel_soft_sync;

	assign sel_io_update = edge_on & (fn == `MFPD_FN_IO_UPDATE);
	assign sel_clr_watchdog = edge_on & (fn == `MFPD_FN_CLR_WATCHDOG);
	assign sel_clr_irq = edge_on & (fn == `MFPD_FN_CLR_IRQ);
	assign sel_tw_reset = edge_on & (fn == `MFPD_FN_TW_RESET);
	assign sel_ph_reset = edge_on & (fn == `MFPD_FN_PH_RESET);
	assign sel_ph_inc = edge_on & (fn == `MFPD_FN_PH_INC);
	assign sel_ph_dec = edge_on & (fn == `MFPD_FN_PH_DEC);
	assign sel_soft_sync = edge_on & (fn == `MFPD_FN_SOFT_SYNC);

	// ----------------------------------------
	// Next output values; software and pin have equal effect.
	// ----------------------------------------
	reg next_io_update;
	reg next_power_down;
	reg next_clr_watchdog;
	reg next_clr_irq;
	reg next_tw_history_reset;
	reg next_user_holdover;
	reg next_user_freerun;
	reg next_phase_reset;
	reg next_phase_inc;
	reg next_phase_dec;
	reg [3:0] next_ref_mon_override;
	reg [3:0] next_force_val_timeout;
	reg [5:0] next_clock_output_en;
	reg next_soft_sync;

	always @* begin
		next_io_update = (w_io & wdata[0]) | sel_io_update;
		next_power_down = sw_power | sel_power_down;
		next_clr_watchdog = (w_clear & wdata[0]) | sel_clr_watchdog;
		next_clr_irq = (w_clear & wdata[1]) | sel_clr_irq;
		next_tw_history_reset = (w_clear & wdata[2]) | sel_tw_reset;
		next_user_holdover = sw_holdover | sel_holdover;
		next_user_freerun = sw_freerun | sel_freerun;
		next_phase_reset = (w_phase & wdata[2]) | sel_ph_reset;
		next_phase_inc = (w_phase & wdata[0]) | sel_ph_inc;
		next_phase_dec = (w_phase & wdata[1]) | sel_ph_dec;
		next_ref_mon_override = sw_mon | pin_mon;
		next_force_val_timeout = sw_val | pin_val;
		next_clock_output_en = sw_out | pin_out;
		next_soft_sync = (w_sync & wdata[`MFPD_BIT_SOFT_SYNC]) | sel_soft_sync;
	end

	// ----------------------------------------
	// Output flops.
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (!resetn) begin
			io_update <= 1'b0;
			power_down <= 1'b0;
			clr_watchdog <= 1'b0;
			clr_irq <= 1'b0;
			tw_history_reset <= 1'b0;
			user_holdover <= 1'b0;
			user_freerun <= 1'b0;
			phase_reset <= 1'b0;
			phase_inc <= 1'b0;
			phase_dec <= 1'b0;
			ref_mon_override <= 4'h0;
			force_val_timeout <= 4'h0;
			clock_output_en <= 6'h00;
			soft_sync <= 1'b0;
		end else begin
			io_update <= next_io_update;
			power_down <= next_power_down;
			clr_watchdog <= next_clr_watchdog;
			clr_irq <= next_clr_irq;
			tw_history_reset <= next_tw_history_reset;
			user_holdover <= next_user_holdover;
			user_freerun <= next_user_freerun;
			phase_reset <= next_phase_reset;
			phase_inc <= next_phase_inc;
			phase_dec <= next_phase_dec;
			ref_mon_override <= next_ref_mon_override;
			force_val_timeout <= next_force_val_timeout;
			clock_output_en <= next_clock_output_en;
			soft_sync <= next_soft_sync;
		end
	end

	// ----------------------------------------
	// Read port.
	// ----------------------------------------
	reg [7:0] next_rdata;

	always @* begin
		next_rdata = 8'h00;
		if (rd) begin
			case (addr)
			`MFPD_ADDR_CFG: next_rdata = cfg;
			`MFPD_ADDR_POWER: next_rdata = {7'h00, sw_power};
			`MFPD_ADDR_LOOP_MODE: next_rdata = {1'b0, sw_holdover, sw_freerun, 5'h00};
			`MFPD_ADDR_MON_OVERRIDE: next_rdata = {4'h0, sw_mon};
			`MFPD_ADDR_VAL_TIMEOUT: next_rdata = {4'h0, sw_val};
			`MFPD_ADDR_OUT_EN0: next_rdata = {7'h00, sw_out[0]};
			`MFPD_ADDR_OUT_EN1: next_rdata = {7'h00, sw_out[1]};
			`MFPD_ADDR_OUT_EN2: next_rdata = {7'h00, sw_out[2]};
			`MFPD_ADDR_OUT_EN3: next_rdata = {7'h00, sw_out[3]};
			`MFPD_ADDR_OUT_EN4: next_rdata = {7'h00, sw_out[4]};
			`MFPD_ADDR_OUT_EN5: next_rdata = {7'h00, sw_out[5]};
			`MFPD_ADDR_STATUS: next_rdata = {7'h00, pin_lvl};
			default: next_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end
endmodule // mfpd_top

`default_nettype wire

// ### test/mfpd_board.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Board logic driving the multifunction pin.
// ----------------------------------------
module mfpd_board (
	input wire logic clk_sys,
	input wire logic hold,
	output var logic pin_in
);
	initial pin_in = 1'b0;
	always @(posedge clk_sys) pin_in <= hold;
endmodule // mfpd_board
`default_nettype wire

// ### test/mfpd_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module mfpd_top_assertions (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic pin_in,
	input wire logic io_update,
	input wire logic power_down,
	input wire logic clr_watchdog,
	input wire logic clr_irq,
	input wire logic user_holdover,
	input wire logic phase_inc,
	input wire logic [5:0] clock_output_en,
	input wire logic soft_sync
);
	reg [7:0] cfg;
	always @(posedge clk_sys) begin
		if (!resetn) cfg <= 8'h00;
		else if (wr && addr == 16'h0000) cfg <= wdata;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence edge_s; $rose(pin_in); endsequence
	sequence held_s; pin_in [*4]; endsequence
	pin_update_a: assert property ((cfg == 8'h01) ##0 edge_s |-> ##3 io_update)
		else $error("pin edge gave no update pulse");
	power_level_a: assert property (held_s ##0 (cfg == 8'h02) |-> power_down)
		else $error("power down does not follow pin");
	watchdog_pulse_a: assert property ((cfg == 8'h03) ##0 edge_s |-> ##3 clr_watchdog)
		else $error("pin edge gave no watchdog clear");
	irq_write_a: assert property (wr && addr == 16'h0a03 && wdata[1] |=> clr_irq)
		else $error("write gave no interrupt clear");
	holdover_write_a: assert property (wr && addr == 16'h0a01 && wdata[6] |-> ##2 user_holdover)
		else $error("stored holdover bit not seen");
	step_once_a: assert property ((cfg == 8'h13) ##0 edge_s |-> ##3 phase_inc ##1 !phase_inc)
		else $error("phase step not a single pulse");
	outputs_all_a: assert property (held_s ##0 (cfg == 8'h46) |-> clock_output_en == 6'h3f)
		else $error("not all outputs enabled");
	soft_sync_a: assert property ((cfg == 8'h47) ##0 edge_s |-> ##3 soft_sync)
		else $error("pin edge gave no soft sync");
	output_mode_a: assert property (cfg[7] ##0 edge_s |-> ##3 !soft_sync)
		else $error("pin acted while set as output");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule // mfpd_top_assertions
bind mfpd_top mfpd_top_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .io_update(io_update),
	.power_down(power_down), .clr_watchdog(clr_watchdog), .clr_irq(clr_irq),
	.user_holdover(user_holdover), .phase_inc(phase_inc), .clock_output_en(clock_output_en),
	.soft_sync(soft_sync));
`default_nettype wire

// ### test/mfpd_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mfpd_top_tb;
	reg clk_sys = 1'b0;
	reg resetn = 1'b0;
	reg [15:0] addr = 16'h0000;
	reg [7:0] wdata = 8'h00;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg hold = 1'b0;
	reg [24:0] acc;
	integer n_mismatch = 0;
	integer samples_checked = 0;
	integer cycles = 0;
	integer i;
	wire pin_in, io_update, power_down, clr_watchdog, clr_irq, tw_history_reset;
	wire user_holdover, user_freerun, phase_reset, phase_inc, phase_dec, soft_sync;
	wire [7:0] rdata;
	wire [3:0] ref_mon_override, force_val_timeout;
	wire [5:0] clock_output_en;
	wire [24:0] outv = {io_update, power_down, clr_watchdog, clr_irq, tw_history_reset,
		user_holdover, user_freerun, phase_reset, phase_inc, phase_dec, ref_mon_override,
		force_val_timeout, clock_output_en, soft_sync};
	always #20 clk_sys = ~clk_sys;
	mfpd_board board (.clk_sys(clk_sys), .hold(hold), .pin_in(pin_in));
	mfpd_top dut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .pin_in(pin_in), .io_update(io_update),
		.power_down(power_down), .clr_watchdog(clr_watchdog), .clr_irq(clr_irq),
		.tw_history_reset(tw_history_reset), .user_holdover(user_holdover),
		.user_freerun(user_freerun), .phase_reset(phase_reset), .phase_inc(phase_inc),
		.phase_dec(phase_dec), .ref_mon_override(ref_mon_override),
		.force_val_timeout(force_val_timeout), .clock_output_en(clock_output_en),
		.soft_sync(soft_sync));
	task check(input string name, input [24:0] seen, input [24:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %0s expected %h seen %h", name, exp, seen);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task wr_reg(input [15:0] a, input [7:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task rd_reg(input [15:0] a, input [7:0] e);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 check("rdata", {17'h0, rdata}, {17'h0, e});
	endtask
	task sw_case(input [15:0] a, input [7:0] d, input [24:0] e);
		wr_reg(a, d);
		#1 acc = outv;
		@(posedge clk_sys);
		#1 acc = acc | outv;
		check("sw on", acc, e);
		wr_reg(a, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1 check("sw off", outv, 25'h0);
	endtask
	function [24:0] exp_of(input [7:0] c);
		begin
			exp_of = 25'h0;
			if (c >= 8'h01 && c <= 8'h05) exp_of = 25'h1 << (25 - c);
			if (c >= 8'h10 && c <= 8'h14) exp_of = 25'h1 << (35 - c);
			if (c[7:2] == 6'h08) exp_of = 25'h1 << (11 + c[1:0]);
			if (c[7:2] == 6'h0c) exp_of = 25'h1 << (7 + c[1:0]);
			if (c >= 8'h40 && c <= 8'h45) exp_of = 25'h1 << (1 + c[2:0]);
			if (c == 8'h46) exp_of = 25'h7e;
			if (c == 8'h47) exp_of = 25'h1;
		end
	endfunction
	task pin_case(input [7:0] c);
		wr_reg(16'h0000, c);
		rd_reg(16'h0000, c);
		@(posedge clk_sys) hold <= 1'b1;
		acc = 25'h0;
		repeat (6) begin
			@(posedge clk_sys);
			#1 acc = acc | outv;
		end
		check("pin on", acc, exp_of(c));
		rd_reg(16'h0a10, 8'h01);
		@(posedge clk_sys) hold <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1 check("pin off", outv, 25'h0);
	endtask
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 10000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		rd_reg(16'h0000, 8'h00);
		wr_reg(16'h0a01, 8'h40);
		repeat (2) @(posedge clk_sys);
		#1 check("holdover", user_holdover, 1'b1);
		rd_reg(16'h0a01, 8'h40);
		wr_reg(16'h0a01, 8'h00);
		wr_reg(16'h0a03, 8'h02);
		#1 check("clr_irq", clr_irq, 1'b1);
		rd_reg(16'h0a03, 8'h00);
		rd_reg(16'h1234, 8'h00);
		sw_case(16'h0005, 8'h01, 25'h1000000);
		sw_case(16'h0a00, 8'h01, 25'h0800000);
		sw_case(16'h0a03, 8'h07, 25'h0700000);
		sw_case(16'h0a01, 8'h60, 25'h00c0000);
		sw_case(16'h0a0a, 8'h07, 25'h0038000);
		sw_case(16'h0a0c, 8'h0f, 25'h0007800);
		sw_case(16'h0a0b, 8'h0f, 25'h0000780);
		sw_case(16'h0501, 8'h01, 25'h0000002);
		sw_case(16'h0505, 8'h01, 25'h0000004);
		sw_case(16'h0506, 8'h01, 25'h0000008);
		sw_case(16'h050a, 8'h01, 25'h0000010);
		sw_case(16'h050b, 8'h01, 25'h0000020);
		sw_case(16'h050f, 8'h01, 25'h0000040);
		sw_case(16'h0a02, 8'h02, 25'h0000001);
		for (i = 0; i < 129; i = i + 1) pin_case(i == 128 ? 8'hc7 : i[7:0]);
		print_verdict;
	end
endmodule // mfpd_top_tb
`default_nettype wire
